// file: inc/pvc_pkg.sv
// Constants, register map and carrier types for the process-value conditioning block.
// Assumes one 10 MHz system clock and a synchronous active-high reset.
package pvc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SAMPLE_PERIOD_MS = 100;
    localparam int unsigned SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 20;

    localparam logic [7:0] ADDR_RANGE_TYPE = 8'h00;
    localparam logic [7:0] ADDR_DECIMAL = 8'h04;
    localparam logic [7:0] ADDR_RANGE_LOW = 8'h08;
    localparam logic [7:0] ADDR_RANGE_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_GAIN = 8'h10;
    localparam logic [7:0] ADDR_OFFSET = 8'h14;
    localparam logic [7:0] ADDR_FILTER = 8'h18;
    localparam logic [7:0] ADDR_SPECIAL = 8'h1C;
    localparam logic [7:0] ADDR_TRIM = 8'h20;
    localparam logic [7:0] ADDR_DROPOUT = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_PV = 8'h2C;

    localparam int STAT_ALARM_HI = 0;
    localparam int STAT_ALARM_LO = 1;
    localparam int STAT_FLASH = 2;
    localparam int STAT_VISIBLE = 3;
    localparam int STAT_SHOWING = 4;
    localparam int HOLD_PLAIN = 0;
    localparam int HOLD_MAX = 1;
    localparam int HOLD_MIN = 2;

    localparam logic [7:0] TYPE_COMPAT = 8'h03;
    localparam logic [7:0] DC_FIRST = 8'h51;
    localparam logic [7:0] DC_LAST = 8'h5A;
    localparam logic [7:0] RTD_FIRST = 8'h29;
    localparam logic [7:0] RTD_LAST = 8'h44;
    localparam logic [7:0] BAR_A_FIRST = 8'h29;
    localparam logic [7:0] BAR_A_LAST = 8'h34;
    localparam logic [7:0] BAR_B_FIRST = 8'h3F;
    localparam logic [7:0] BAR_B_LAST = 8'h44;

    localparam logic signed [15:0] SET_MIN = 16'shF831;
    localparam logic signed [15:0] SET_MAX = 16'sh270F;
    localparam logic signed [15:0] RANGE_HI_DEF = 16'sh03E8;
    localparam logic signed [15:0] RATIO_MIN = 16'sh0001;
    localparam logic signed [15:0] RATIO_MAX = 16'sh270F;
    localparam logic signed [15:0] RATIO_DEF = 16'sh03E8;
    localparam logic signed [15:0] FILT_MAX = 16'sh04B0;
    localparam logic signed [15:0] DROPOUT_MAX = 16'sh03E8;
    localparam logic signed [15:0] TRIM_LIMIT = 16'sh07D0;
    localparam logic signed [15:0] TRIM_NEG = 16'shF830;
    localparam logic signed [15:0] ZERO16 = 16'sh0000;
    localparam logic signed [31:0] FULL_SCALE = 32'sh00002710;
    localparam logic signed [31:0] RATIO_UNIT = 32'sh000003E8;
    localparam logic signed [31:0] CLAMP_DIV = 32'sh0000000A;
    localparam logic signed [31:0] DROPOUT_SCALE = 32'sh0000000A;
    localparam logic [1:0] DP_MAX_DC = 2'h3;
    localparam logic [1:0] DP_MAX_OTHER = 2'h1;
    localparam logic [3:0] SPECIAL_BARRIER = 4'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {ADJ_IDLE = 1'b0, ADJ_SHOWN = 1'b1} pvc_adj_type;

    typedef struct packed {
        logic valid;
        logic signed [15:0] value;
    } pvc_sample_type;

    typedef struct packed {
        logic signed [15:0] lo;
        logic signed [15:0] hi;
    } pvc_limits_type;

    typedef struct packed {
        logic valid;
        logic signed [15:0] value;
        logic alarm_hi;
        logic alarm_lo;
        logic flash;
    } pvc_pv_type;

    typedef struct packed {
        logic awready, wready, bvalid, aw_ok, w_ok, wfull, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [7:0] awaddr;
        logic [31:0] wdata, rdata;
        logic [7:0] range_type;
        logic [1:0] dp;
        logic signed [15:0] rlo, rhi, ratio, bias, filt, dropout, trim, trim_out, adj_val, raw;
        logic [3:0] special;
        logic [TICK_W-1:0] tick_cnt;
        logic signed [31:0] lag;
        pvc_pv_type pvo;
        pvc_adj_type adj;
        logic showing, vis;
        logic [2:0] hold_s1, hold_s2;
        logic key_s1, key_s2, key_s3;
    } pvc_state_type;

    localparam pvc_state_type PVC_RESET = '{rhi: RANGE_HI_DEF, ratio: RATIO_DEF,
        awready: 1'b1, wready: 1'b1, arready: 1'b1, adj: ADJ_IDLE, default: '0};
endpackage

// file: hw/pvc_conditioner.sv
// Process-value conditioning: scaling, root extraction, ratio and bias, lag filter,
// holds, clamping, limit alarms and the barrier wiring trim, with an AXI4-Lite slave.
// Assumes the converter and measurement inputs share sys_clk; hold and key inputs are pins.
`timescale 1ns/1ps
module pvc_conditioner
    import pvc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // AXI4-Lite register slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converted reading and sensor range table
    input wire pvc_sample_type stage_input_value,
    input wire pvc_limits_type range_table_limits,
    input wire logic signed [15:0] line_resistance_diff,
    // Operator pins
    input wire logic [2:0] hold_pins,
    input wire logic enter_key,
    // Results
    output pvc_pv_type stage_output_value,
    output logic [1:0] decimal_point_setting,
    output logic signed [15:0] barrier_resistance_trim,
    output logic barrier_item_visible,
    output logic barrier_diff_showing,
    output logic signed [15:0] barrier_diff_value
);
    pvc_state_type st;
    pvc_state_type next_st;
    logic is_dc, is_rtd, vis, tick, key_edge, ok, wfits;
    logic signed [15:0] wd;
    logic signed [31:0] lo, hi, span, pv_lo, pv_hi, sq, scaled, corr, filtered, prev, held;
    logic signed [31:0] clamped;
    logic [31:0] rd_word;

    function automatic logic in_span(input logic [7:0] v, input logic [7:0] a,
        input logic [7:0] b);
        return (v >= a) && (v <= b);
    endfunction

    function automatic logic in_set(input logic signed [15:0] v, input logic signed [15:0] a,
        input logic signed [15:0] b);
        return (v >= a) && (v <= b);
    endfunction

    // Bitwise root search; one multiplier per step keeps it combinational.
    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] r;
        logic [15:0] c;
        r = '0;
        for (int i = 15; i >= 0; i--)
        begin
            c = r | (16'h0001 << i);
            r = ((32'(c) * 32'(c)) <= v) ? c : r;
        end
        return r;
    endfunction

    always_comb
    begin
        next_st = st;
        is_dc = in_span(st.range_type, DC_FIRST, DC_LAST);
        is_rtd = in_span(st.range_type, RTD_FIRST, RTD_LAST);
        tick = (st.tick_cnt == TICK_W'(SAMPLE_CYCLES - 1));
        key_edge = st.key_s2 & ~st.key_s3;
        wd = st.wdata[15:0];
        wfits = (st.wdata[31:16] == {16{st.wdata[15]}}) && st.wfull;
        ok = 1'b0;
        rd_word = '0;

        next_st.hold_s1 = hold_pins;
        next_st.hold_s2 = st.hold_s1;
        next_st.key_s1 = enter_key;
        next_st.key_s2 = st.key_s1;
        next_st.key_s3 = st.key_s2;
        next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
        next_st.raw = stage_input_value.valid ? stage_input_value.value : st.raw;

        // Sensor ranges take their limits from the range table.
        lo = is_dc ? 32'(st.rlo) : 32'(range_table_limits.lo);
        hi = is_dc ? 32'(st.rhi) : 32'(range_table_limits.hi);
        span = hi - lo;
        pv_lo = lo - span / CLAMP_DIV;
        pv_hi = hi + span / CLAMP_DIV;

        // The root stage only acts strictly inside 0..100 % of the input.
        sq = 32'(st.raw);
        if (is_dc && st.raw > ZERO16 && 32'(st.raw) < FULL_SCALE)
        begin
            if (32'(st.raw) < 32'(st.dropout) * DROPOUT_SCALE)
            begin
                sq = '0;
            end
            else if (st.dropout != ZERO16)
            begin
                sq = 32'(isqrt(32'(32'(st.raw) * FULL_SCALE)));
            end
        end

        // Processing order is scale, ratio/bias, filter, hold, clamp.
        scaled = is_dc ? lo + (span * sq) / FULL_SCALE : 32'(st.raw);
        corr = (scaled * 32'(st.ratio)) / RATIO_UNIT + 32'(st.bias);
        filtered = st.lag + (corr - st.lag) / (32'(st.filt) + 32'sh1);
        prev = 32'(st.pvo.value);
        // Plain hold outranks max hold, which outranks min hold.
        held = st.hold_s2[HOLD_PLAIN] ? prev
            : st.hold_s2[HOLD_MAX] ? ((filtered > prev) ? filtered : prev)
            : st.hold_s2[HOLD_MIN] ? ((filtered < prev) ? filtered : prev)
            : filtered;
        clamped = (held > pv_hi) ? pv_hi : ((held < pv_lo) ? pv_lo : held);

        next_st.pvo.valid = tick;
        next_st.pvo.flash = |st.hold_s2;
        if (tick)
        begin
            next_st.lag = filtered;
            next_st.pvo.value = clamped[15:0];
            next_st.pvo.alarm_hi = scaled > pv_hi;
            next_st.pvo.alarm_lo = scaled < pv_lo;
        end

        // Barrier trim item and its two-press measurement sequence.
        vis = is_rtd && (st.special == SPECIAL_BARRIER)
            && (in_span(st.range_type, BAR_A_FIRST, BAR_A_LAST)
            || in_span(st.range_type, BAR_B_FIRST, BAR_B_LAST));
        next_st.vis = vis;
        case (st.adj)
            ADJ_IDLE:
            begin
                if (vis && key_edge)
                begin
                    next_st.adj = ADJ_SHOWN;
                    next_st.adj_val = line_resistance_diff;
                end
            end
            ADJ_SHOWN:
            begin
                if (!vis)
                begin
                    next_st.adj = ADJ_IDLE;
                end
                else if (key_edge)
                begin
                    next_st.adj = ADJ_IDLE;
                    next_st.trim = (st.adj_val >= TRIM_LIMIT || st.adj_val <= TRIM_NEG)
                        ? ZERO16 : st.adj_val;
                end
            end
            default:
            begin
                next_st.adj = ADJ_IDLE;
            end
        endcase
        next_st.showing = (next_st.adj == ADJ_SHOWN);
        next_st.trim_out = is_rtd ? st.trim : ZERO16;

        // Write channel: address and data may arrive in either order.
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_ok = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_ok = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wfull = &s_axi_wstrb;
        end
        next_st.bvalid = st.bvalid && !s_axi_bready;
        if (st.aw_ok && st.w_ok && !st.bvalid)
        begin
            case (st.awaddr)
                ADDR_RANGE_TYPE:
                begin
                    ok = st.wfull && (st.wdata[31:8] == '0);
                    if (ok)
                    begin
                        next_st.range_type = st.wdata[7:0];
                        next_st.rlo = ZERO16;
                        next_st.rhi = RANGE_HI_DEF;
                        next_st.dp = (st.wdata[7:0] == TYPE_COMPAT) ? '0 : st.dp;
                    end
                end
                ADDR_DECIMAL:
                begin
                    // Sensor ranges allow one fractional digit at most.
                    ok = st.wfull && (st.range_type != TYPE_COMPAT) && (st.wdata[31:2] == '0)
                        && (st.wdata[1:0] <= (is_dc ? DP_MAX_DC : DP_MAX_OTHER));
                    next_st.dp = ok ? st.wdata[1:0] : st.dp;
                end
                ADDR_RANGE_LOW:
                begin
                    ok = is_dc && wfits && in_set(wd, SET_MIN, SET_MAX);
                    next_st.rlo = ok ? wd : st.rlo;
                end
                ADDR_RANGE_HIGH:
                begin
                    ok = is_dc && wfits && in_set(wd, SET_MIN, SET_MAX);
                    next_st.rhi = ok ? wd : st.rhi;
                end
                ADDR_GAIN:
                begin
                    ok = wfits && in_set(wd, RATIO_MIN, RATIO_MAX);
                    next_st.ratio = ok ? wd : st.ratio;
                end
                ADDR_OFFSET:
                begin
                    ok = wfits && in_set(wd, SET_MIN, SET_MAX);
                    next_st.bias = ok ? wd : st.bias;
                end
                ADDR_FILTER:
                begin
                    ok = wfits && in_set(wd, ZERO16, FILT_MAX);
                    next_st.filt = ok ? wd : st.filt;
                end
                ADDR_SPECIAL:
                begin
                    ok = st.wfull && (st.wdata[31:4] == '0);
                    next_st.special = ok ? st.wdata[3:0] : st.special;
                end
                ADDR_DROPOUT:
                begin
                    ok = wfits && in_set(wd, ZERO16, DROPOUT_MAX);
                    next_st.dropout = ok ? wd : st.dropout;
                end
                default:
                begin
                    ok = 1'b0;
                end
            endcase
            next_st.aw_ok = 1'b0;
            next_st.w_ok = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.awready = !next_st.aw_ok && !next_st.bvalid;
        next_st.wready = !next_st.w_ok && !next_st.bvalid;

        // Read channel answers one cycle after the address is taken.
        case (s_axi_araddr)
            ADDR_RANGE_TYPE: rd_word = 32'(st.range_type);
            ADDR_DECIMAL: rd_word = 32'(st.dp);
            ADDR_RANGE_LOW: rd_word = lo;
            ADDR_RANGE_HIGH: rd_word = hi;
            ADDR_GAIN: rd_word = 32'(st.ratio);
            ADDR_OFFSET: rd_word = 32'(st.bias);
            ADDR_FILTER: rd_word = 32'(st.filt);
            ADDR_SPECIAL: rd_word = 32'(st.special);
            ADDR_TRIM: rd_word = 32'(st.trim);
            ADDR_DROPOUT: rd_word = 32'(st.dropout);
            ADDR_STATUS:
            begin
                rd_word[STAT_ALARM_HI] = st.pvo.alarm_hi;
                rd_word[STAT_ALARM_LO] = st.pvo.alarm_lo;
                rd_word[STAT_FLASH] = st.pvo.flash;
                rd_word[STAT_VISIBLE] = st.vis;
                rd_word[STAT_SHOWING] = st.showing;
            end
            ADDR_PV: rd_word = 32'(st.pvo.value);
            default: rd_word = '0;
        endcase
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = (s_axi_araddr > ADDR_PV || s_axi_araddr[1:0] != 2'h0)
                ? RESP_SLVERR : RESP_OKAY;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st <= PVC_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign stage_output_value = st.pvo;
    assign decimal_point_setting = st.dp;
    assign barrier_resistance_trim = st.trim_out;
    assign barrier_item_visible = st.vis;
    assign barrier_diff_showing = st.showing;
    assign barrier_diff_value = st.adj_val;

    property p_dp_compat;
        @(posedge sys_clk) disable iff (reset) st.range_type == TYPE_COMPAT |-> st.dp == 2'h0;
    endproperty
    a_dp_compat: assert property (p_dp_compat) else $error("decimal not zero for type 3");
    property p_limit_ro;
        @(posedge sys_clk) disable iff (reset)
        (st.aw_ok && st.w_ok && !st.bvalid && !is_dc && st.awaddr == ADDR_RANGE_LOW)
        |=> st.bvalid && st.bresp == RESP_SLVERR && $stable(st.rlo);
    endproperty
    a_limit_ro: assert property (p_limit_ro) else $error("sensor limit write accepted");
    property p_trim_ro;
        @(posedge sys_clk) disable iff (reset)
        st.bvalid && st.awaddr == ADDR_TRIM |-> st.bresp == RESP_SLVERR;
    endproperty
    a_trim_ro: assert property (p_trim_ro) else $error("trim write accepted");
    property p_clamp;
        @(posedge sys_clk) disable iff (reset)
        tick |=> 32'(st.pvo.value) <= $past(pv_hi) && 32'(st.pvo.value) >= $past(pv_lo);
    endproperty
    a_clamp: assert property (p_clamp) else $error("value outside clamp limits");
    property p_hold;
        @(posedge sys_clk) disable iff (reset)
        st.hold_s2[HOLD_PLAIN] ##1 st.hold_s2[HOLD_PLAIN] |-> $stable(st.pvo.value);
    endproperty
    a_hold: assert property (p_hold) else $error("value moved during hold");
    property p_max;
        @(posedge sys_clk) disable iff (reset)
        tick && st.hold_s2 == 3'h2 && prev <= pv_hi && prev >= pv_lo
        |=> st.pvo.value >= $past(st.pvo.value);
    endproperty
    a_max: assert property (p_max) else $error("max hold value fell");
    property p_min;
        @(posedge sys_clk) disable iff (reset)
        tick && st.hold_s2 == 3'h4 && prev <= pv_hi && prev >= pv_lo
        |=> st.pvo.value <= $past(st.pvo.value);
    endproperty
    a_min: assert property (p_min) else $error("min hold value rose");
    property p_flash;
        @(posedge sys_clk) disable iff (reset) (|st.hold_s2) |=> st.pvo.flash;
    endproperty
    a_flash: assert property (p_flash) else $error("hold without flash");
    property p_refuse;
        @(posedge sys_clk) disable iff (reset)
        st.adj == ADJ_SHOWN && vis && key_edge && st.adj_val >= TRIM_LIMIT |=> st.trim == ZERO16;
    endproperty
    a_refuse: assert property (p_refuse) else $error("large difference stored");
    property p_special_reset;
        @(posedge sys_clk) disable iff (reset) $fell(reset) |-> st.special == 4'h0;
    endproperty
    a_special_reset: assert property (p_special_reset) else $error("special not cleared");
endmodule

// file: verif/pvc_sensor_model.sv
// Converter model: offers the given level as a sample every fourth clock.
// Assumes it shares sys_clk and reset with the conditioner.
`timescale 1ns/1ps
module pvc_sensor_model
    import pvc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Reading to send and sample stream
    input wire logic signed [15:0] level,
    output pvc_sample_type sample
);
    logic [1:0] cnt;
    always_ff @(posedge sys_clk)
    begin
        cnt <= reset ? 2'h0 : cnt + 2'h1;
        sample.valid <= !reset && cnt == 2'h3;
        // The value toggles between samples so a stale word never looks valid.
        sample.value <= (cnt == 2'h3) ? level : ~sample.value;
    end
endmodule

// file: verif/pvc_conditioner_tb.sv
// Testbench for the conditioner: registers, sample path, holds and barrier trim.
// Assumes a sample tick shortened to 20 clocks and fixed table limits 0..1000.
`timescale 1ns/1ps
module pvc_conditioner_tb import pvc_pkg::*;;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0, enter = '0;
    logic [31:0] wdata = '0, rdata;
    logic [2:0] hold = '0;
    logic signed [15:0] level = '0, diff = '0, trim, dval;
    logic awready, wready, bvalid, arready, rvalid, vis, showing;
    logic [1:0] bresp, rresp, dp;
    pvc_sample_type smp;
    pvc_pv_type pv;
    int n_errors = 0, check_count = 0;

    pvc_sensor_model i_pvc_sensor_model (.sys_clk(sys_clk), .reset(reset), .level(level),
        .sample(smp));
    pvc_conditioner #(.SAMPLE_CYCLES(20)) i_pvc_conditioner (.sys_clk(sys_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .stage_input_value(smp), .range_table_limits('{lo: 16'sh0000, hi: 16'sh03E8}),
        .line_resistance_diff(diff), .hold_pins(hold), .enter_key(enter),
        .stage_output_value(pv), .decimal_point_setting(dp), .barrier_resistance_trim(trim),
        .barrier_item_visible(vis), .barrier_diff_showing(showing), .barrier_diff_value(dval));

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    // Waits for n output pulses, then compares value and {alarm_hi, alarm_lo, flash}.
    task automatic pvchk(input int n, input logic signed [15:0] e, input logic [2:0] f);
        repeat (n)
        begin
            do @(posedge sys_clk); while (pv.valid !== 1'h1);
        end
        chk("pv", 32'(e), 32'(pv.value));
        chk("flags", 32'(f), 32'({pv.alarm_hi, pv.alarm_lo, pv.flash}));
    endtask

    task automatic press();
        enter <= 1'h1;
        repeat (6) @(posedge sys_clk);
        enter <= 1'h0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic end_sim();
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #3000000;
        n_errors++;
        end_sim();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'h0;
        rd(ADDR_DECIMAL, 32'h0, RESP_OKAY);
        rd(ADDR_RANGE_HIGH, 32'h3E8, RESP_OKAY);
        rd(ADDR_GAIN, 32'h3E8, RESP_OKAY);
        rd(ADDR_SPECIAL, 32'h0, RESP_OKAY);
        wr(ADDR_RANGE_LOW, 32'h0, RESP_SLVERR);
        wr(ADDR_DECIMAL, 32'h2, RESP_SLVERR);
        wr(8'h30, 32'h0, RESP_SLVERR);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(ADDR_TRIM, 32'h5, RESP_SLVERR);
        wr(ADDR_RANGE_TYPE, 32'h51, RESP_OKAY);
        wr(ADDR_RANGE_LOW, 32'hFFFFF831, RESP_OKAY);
        rd(ADDR_RANGE_LOW, 32'hFFFFF831, RESP_OKAY);
        wr(ADDR_RANGE_HIGH, 32'h2710, RESP_SLVERR);
        wr(ADDR_DECIMAL, 32'h3, RESP_OKAY);
        chk("dp", 32'h3, 32'(dp));
        wr(ADDR_RANGE_TYPE, 32'h3, RESP_OKAY);
        rd(ADDR_DECIMAL, 32'h0, RESP_OKAY);
        wr(ADDR_DECIMAL, 32'h1, RESP_SLVERR);
        wr(ADDR_RANGE_TYPE, 32'h51, RESP_OKAY);
        wr(ADDR_GAIN, 32'h7D0, RESP_OKAY);
        wr(ADDR_OFFSET, 32'hA, RESP_OKAY);
        level <= 16'sh1388;
        pvchk(2, 16'sh03F2, 3'h0);
        wr(ADDR_GAIN, 32'h3E8, RESP_OKAY);
        wr(ADDR_OFFSET, 32'h0, RESP_OKAY);
        level <= 16'sh2EE0;
        pvchk(2, 16'sh044C, 3'h4);
        level <= 16'shF830;
        pvchk(2, 16'shFF9C, 3'h2);
        level <= 16'sh0FA0;
        pvchk(2, 16'sh0190, 3'h0);
        wr(ADDR_FILTER, 32'h1, RESP_OKAY);
        pvchk(1, 16'sh0190, 3'h0);
        level <= 16'sh1770;
        pvchk(1, 16'sh01F4, 3'h0);
        pvchk(1, 16'sh0226, 3'h0);
        wr(ADDR_FILTER, 32'h0, RESP_OKAY);
        level <= 16'sh0BB8;
        pvchk(2, 16'sh012C, 3'h0);
        hold <= 3'h1;
        pvchk(2, 16'sh012C, 3'h1);
        level <= 16'sh1770;
        pvchk(2, 16'sh012C, 3'h1);
        hold <= 3'h2;
        pvchk(2, 16'sh0258, 3'h1);
        level <= 16'sh07D0;
        pvchk(2, 16'sh0258, 3'h1);
        hold <= 3'h4;
        pvchk(2, 16'sh00C8, 3'h1);
        level <= 16'sh0FA0;
        pvchk(2, 16'sh00C8, 3'h1);
        hold <= 3'h0;
        pvchk(2, 16'sh0190, 3'h0);
        wr(ADDR_DROPOUT, 32'h64, RESP_OKAY);
        level <= 16'sh01F4;
        pvchk(2, 16'sh0000, 3'h0);
        level <= 16'sh09C4;
        pvchk(2, 16'sh01F4, 3'h0);
        wr(ADDR_DROPOUT, 32'h0, RESP_OKAY);
        // Keep the sensor reading inside the clamp span so the status reads show no alarm.
        level <= 16'sh0190;
        wr(ADDR_RANGE_TYPE, 32'h29, RESP_OKAY);
        wr(ADDR_SPECIAL, 32'h5, RESP_OKAY);
        rd(ADDR_STATUS, 32'h8, RESP_OKAY);
        diff <= 16'sh0096;
        press();
        rd(ADDR_STATUS, 32'h18, RESP_OKAY);
        chk("dval", 32'h96, 32'(dval));
        press();
        rd(ADDR_TRIM, 32'h96, RESP_OKAY);
        wr(ADDR_RANGE_TYPE, 32'h3F, RESP_OKAY);
        chk("trim", 32'h96, 32'(trim));
        diff <= 16'sh07D0;
        press();
        press();
        rd(ADDR_TRIM, 32'h0, RESP_OKAY);
        wr(ADDR_RANGE_TYPE, 32'h35, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, RESP_OKAY);
        wr(ADDR_RANGE_TYPE, 32'h3F, RESP_OKAY);
        rd(ADDR_STATUS, 32'h8, RESP_OKAY);
        wr(ADDR_SPECIAL, 32'h0, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, RESP_OKAY);
        end_sim();
    end
endmodule
